// File: rtl/wacfg_pkg.sv
// shared constants and types for the waveform and active term configuration block
package wacfg_pkg;

    localparam int SW = 24;
    localparam int PW = 32;

    localparam logic [7:0] WAVE_MODE_ADDR = 8'h0c;
    localparam logic [7:0] ACT_MODE_ADDR  = 8'h0d;

    localparam logic [7:0] WAVE_MODE_RST  = 8'h00;
    localparam logic [7:0] ACT_MODE_RST   = 8'h3f;
    localparam logic [7:0] WAVE_MODE_MASK = 8'h3f;

    localparam int WAVE_SRC_LSB  = 0;
    localparam int RATE_LSB      = 3;
    localparam int SWAP_BIT      = 5;
    localparam int LINE_TERM_LSB = 0;
    localparam int TERM_LSB      = 3;
    localparam int FORMULA_LSB   = 6;

    localparam logic [2:0] SRC_VA = 3'h0;
    localparam logic [2:0] SRC_VB = 3'h1;
    localparam logic [2:0] SRC_VC = 3'h2;
    localparam logic [2:0] SRC_IA = 3'h3;
    localparam logic [2:0] SRC_IB = 3'h4;
    localparam logic [2:0] SRC_IC = 3'h5;

    localparam logic [1:0] FORM_SUM3   = 2'h0;
    localparam logic [1:0] FORM_TWO_AC = 2'h1;
    localparam logic [1:0] FORM_TWO_A  = 2'h2;
    localparam logic [1:0] FORM_RSV    = 2'h3;

    localparam logic [1:0]  PRESCALE   = 2'h3;
    localparam logic [10:0] RATE_BASE  = 11'h080;

    typedef struct packed {
        logic signed [SW-1:0] va;
        logic signed [SW-1:0] vb;
        logic signed [SW-1:0] vc;
        logic signed [SW-1:0] ia;
        logic signed [SW-1:0] ib;
        logic signed [SW-1:0] ic;
    } wacfg_samples_s;

    typedef struct packed {
        logic signed [PW-1:0] first_p;
        logic signed [PW-1:0] first_d;
        logic signed [PW-1:0] second;
        logic signed [PW-1:0] third_p;
        logic signed [PW-1:0] third_d;
    } wacfg_terms_s;

    typedef struct packed {
        logic signed [PW-1:0] active;
        logic signed [PW-1:0] reactive;
        logic signed [PW-1:0] apparent;
    } wacfg_line_s;

    typedef struct packed {
        logic [1:0]  pre;
        logic [10:0] cnt;
        logic [1:0]  rate;
    } wacfg_div_s;

    typedef struct packed {
        logic [7:0]           wave_mode;
        logic [7:0]           act_mode;
        logic [7:0]           rdata;
        logic [SW-1:0]        wave_sample;
        logic                 wave_valid;
        logic signed [PW-1:0] active_power;
        logic signed [PW-1:0] line_active_power;
        logic signed [PW-1:0] line_active_acc_in;
        logic signed [PW-1:0] line_apparent_acc_in;
        logic [2:0]           neg_sign;
    } wacfg_top_s;

    localparam wacfg_top_s TOP_RST = '{wave_mode: WAVE_MODE_RST, act_mode: ACT_MODE_RST, default: '0};

endpackage

// File: rtl/wacfg_rate_div.sv
// waveform update strobe divider: clock / 3 / (128 << rate)
`timescale 1ns/10ps
`default_nettype none
module wacfg_rate_div
    import wacfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] rate,
    output logic            strobe
);
    wacfg_div_s  st;
    wacfg_div_s  next_st;
    logic [10:0] limit;

    assign limit  = RATE_BASE << rate;
    assign strobe = (st.rate == rate) && (st.pre == PRESCALE - 2'h1) && (st.cnt == limit - 11'h001);

    always_comb begin
        next_st = st;
        if (st.rate != rate) begin
            next_st = '0;
            next_st.rate = rate;
        end else if (st.pre == PRESCALE - 2'h1) begin
            next_st.pre = 2'h0;
            next_st.cnt = strobe ? 11'h000 : st.cnt + 11'h001;
        end else begin
            next_st.pre = st.pre + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // helper: cycles since the previous strobe at a stable rate
    logic [12:0] gap;
    logic        seen;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap  <= 13'h0000;
            seen <= 1'b0;
        end else if (st.rate != rate) begin
            gap  <= 13'h0000;
            seen <= 1'b0;
        end else if (strobe) begin
            gap  <= 13'h0000;
            seen <= 1'b1;
        end else begin
            gap  <= gap + 13'h0001;
        end
    end

    property p_rate_period;
        @(posedge clk) disable iff (!rst_n)
        (strobe && seen) |-> (gap == 13'(3 * (32'd128 << rate) - 1));
    endproperty
    a_rate_period: assert property (p_rate_period) else $error("waveform update period wrong");

endmodule
`default_nettype wire

// File: rtl/wacfg_top.sv
// waveform mode and active term configuration registers with their steering logic
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - three-bit code picks waveform sample source
// - sample rate clock/3/128 up to /1024
// - swap bit reroutes line reactive and active
// - line term bits enable line-cycle terms
// - bit 5 gates first active term
// - bit 4 gates second active term
// - bit 3 gates last active term
// - term bits also enable negative signs
// - any term enable subset is accepted
// - formula field picks sum or two-wattmeter
// - disabled phase sign stays at zero
module wacfg_top
    import wacfg_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic [7:0]      reg_addr,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    input  wire logic [7:0]      reg_wdata,
    output logic [7:0]           reg_rdata,
    input  wire wacfg_samples_s  samples,
    input  wire wacfg_terms_s    terms,
    input  wire wacfg_line_s     line_in,
    output logic [SW-1:0]        wave_sample,
    output logic                 wave_valid,
    output logic signed [PW-1:0] active_power,
    output logic signed [PW-1:0] line_active_power,
    output logic signed [PW-1:0] line_active_acc_in,
    output logic signed [PW-1:0] line_apparent_acc_in,
    output logic [2:0]           pulse_numerator_neg
);
    logic [1:0] rst_sync;
    logic       rst_n;
    wacfg_top_s st;
    wacfg_top_s next_st;
    logic       upd;

    logic [2:0] waveform_source_select;
    logic [1:0] sample_rate_select;
    logic       line_reactive_swap;
    logic [2:0] line_active_term_select;
    logic [2:0] active_term_select;
    logic [1:0] active_formula_select;
    logic signed [PW-1:0] t_first;
    logic signed [PW-1:0] t_second;
    logic signed [PW-1:0] t_third;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign waveform_source_select  = st.wave_mode[WAVE_SRC_LSB +: 3];
    assign sample_rate_select      = st.wave_mode[RATE_LSB +: 2];
    assign line_reactive_swap      = st.wave_mode[SWAP_BIT];
    assign line_active_term_select = st.act_mode[LINE_TERM_LSB +: 3];
    assign active_term_select      = st.act_mode[TERM_LSB +: 3];
    assign active_formula_select   = st.act_mode[FORMULA_LSB +: 2];

    wacfg_rate_div u_div (
        .clk    (clk),
        .rst_n  (rst_n),
        .rate   (sample_rate_select),
        .strobe (upd)
    );

    // formula terms before enabling
    always_comb begin
        t_first  = '0;
        t_second = '0;
        t_third  = '0;
        unique case (active_formula_select)
            FORM_SUM3: begin
                t_first  = terms.first_p;
                t_second = terms.second;
                t_third  = terms.third_p;
            end
            FORM_TWO_AC: begin
                t_first  = terms.first_d;
                t_third  = terms.third_d;
            end
            FORM_TWO_A: begin
                t_first  = terms.first_d;
                t_third  = terms.third_p;
            end
            FORM_RSV: begin
                t_first  = '0;
            end
        endcase
    end

    // sum of enabled terms, bit 2 first term
    function automatic logic signed [PW-1:0] term_sum(input logic [2:0] en,
                                                       input logic signed [PW-1:0] a,
                                                       input logic signed [PW-1:0] b,
                                                       input logic signed [PW-1:0] c);
        logic signed [PW-1:0] s;
        s = '0;
        if (en[2]) begin
            s = s + a;
        end
        if (en[1]) begin
            s = s + b;
        end
        if (en[0]) begin
            s = s + c;
        end
        return s;
    endfunction

    always_comb begin
        next_st = st;
        next_st.wave_valid = 1'b0;
        if (reg_wr && reg_addr == WAVE_MODE_ADDR) begin
            next_st.wave_mode = reg_wdata & WAVE_MODE_MASK;
        end
        if (reg_wr && reg_addr == ACT_MODE_ADDR) begin
            next_st.act_mode = reg_wdata;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                WAVE_MODE_ADDR: next_st.rdata = st.wave_mode;
                ACT_MODE_ADDR:  next_st.rdata = st.act_mode;
                default:        next_st.rdata = 8'h00;
            endcase
        end
        if (upd) begin
            next_st.wave_valid = 1'b1;
            unique case (waveform_source_select)
                SRC_VA:  next_st.wave_sample = samples.va;
                SRC_VB:  next_st.wave_sample = samples.vb;
                SRC_VC:  next_st.wave_sample = samples.vc;
                SRC_IA:  next_st.wave_sample = samples.ia;
                SRC_IB:  next_st.wave_sample = samples.ib;
                SRC_IC:  next_st.wave_sample = samples.ic;
                default: next_st.wave_valid  = 1'b0;
            endcase
        end
        next_st.active_power      = term_sum(active_term_select, t_first, t_second, t_third);
        next_st.line_active_power = term_sum(line_active_term_select, t_first, t_second, t_third);
        if (line_reactive_swap) begin
            next_st.line_active_acc_in   = line_in.reactive;
            next_st.line_apparent_acc_in = line_in.active;
        end else begin
            next_st.line_active_acc_in   = line_in.active;
            next_st.line_apparent_acc_in = line_in.apparent;
        end
        next_st.neg_sign[0] = active_term_select[2] & terms.first_p[PW-1];
        next_st.neg_sign[1] = active_term_select[1] & terms.second[PW-1];
        next_st.neg_sign[2] = active_term_select[0] & terms.third_p[PW-1];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= TOP_RST;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata            = st.rdata;
    assign wave_sample          = st.wave_sample;
    assign wave_valid           = st.wave_valid;
    assign active_power         = st.active_power;
    assign line_active_power    = st.line_active_power;
    assign line_active_acc_in   = st.line_active_acc_in;
    assign line_apparent_acc_in = st.line_apparent_acc_in;
    assign pulse_numerator_neg  = st.neg_sign;

    property p_src_va;
        @(posedge clk) disable iff (!rst_n)
        (upd && waveform_source_select == SRC_VA) |=> (wave_valid && wave_sample == $past(samples.va));
    endproperty
    a_src_va: assert property (p_src_va) else $error("phase a voltage not sampled");

    property p_src_ic;
        @(posedge clk) disable iff (!rst_n)
        (upd && waveform_source_select == SRC_IC) |=> (wave_valid && wave_sample == $past(samples.ic));
    endproperty
    a_src_ic: assert property (p_src_ic) else $error("phase c current not sampled");

    property p_valid_only_on_update;
        @(posedge clk) disable iff (!rst_n)
        wave_valid |-> ($past(upd) && $past(waveform_source_select) <= SRC_IC);
    endproperty
    a_valid_only_on_update: assert property (p_valid_only_on_update) else $error("sample valid without update");

    property p_swap;
        @(posedge clk) disable iff (!rst_n)
        line_reactive_swap |=> (line_active_acc_in == $past(line_in.reactive)
                                && line_apparent_acc_in == $past(line_in.active));
    endproperty
    a_swap: assert property (p_swap) else $error("swap routing wrong");

    property p_line_off;
        @(posedge clk) disable iff (!rst_n)
        (line_active_term_select == 3'h0) |=> (line_active_power == '0);
    endproperty
    a_line_off: assert property (p_line_off) else $error("line terms disabled yet nonzero");

    property p_first_only;
        @(posedge clk) disable iff (!rst_n)
        (active_term_select == 3'h4 && active_formula_select == FORM_SUM3) |=> (active_power == $past(terms.first_p));
    endproperty
    a_first_only: assert property (p_first_only) else $error("first term gating wrong");

    property p_second_only;
        @(posedge clk) disable iff (!rst_n)
        (active_term_select == 3'h2 && active_formula_select == FORM_SUM3) |=> (active_power == $past(terms.second));
    endproperty
    a_second_only: assert property (p_second_only) else $error("second term gating wrong");

    property p_third_diff;
        @(posedge clk) disable iff (!rst_n)
        (active_term_select == 3'h1 && active_formula_select == FORM_TWO_AC) |=> (active_power == $past(terms.third_d));
    endproperty
    a_third_diff: assert property (p_third_diff) else $error("last term gating wrong");

    property p_formula_rsv;
        @(posedge clk) disable iff (!rst_n)
        (active_formula_select == FORM_RSV) |=> (active_power == '0 && line_active_power == '0);
    endproperty
    a_formula_rsv: assert property (p_formula_rsv) else $error("reserved formula not zero");

    property p_neg_b_off;
        @(posedge clk) disable iff (!rst_n)
        !active_term_select[1] |=> !pulse_numerator_neg[1];
    endproperty
    a_neg_b_off: assert property (p_neg_b_off) else $error("phase b sign shown while disabled");

    property p_neg_a;
        @(posedge clk) disable iff (!rst_n)
        active_term_select[2] |=> (pulse_numerator_neg[0] == $past(terms.first_p[PW-1]));
    endproperty
    a_neg_a: assert property (p_neg_a) else $error("phase a sign wrong");

    property p_write_act;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == ACT_MODE_ADDR) |=> (st.act_mode == $past(reg_wdata));
    endproperty
    a_write_act: assert property (p_write_act) else $error("term enable write lost");

    property p_src_vb;
        @(posedge clk) disable iff (!rst_n)
        (upd && waveform_source_select == SRC_VB) |=> (wave_valid && wave_sample == $past(samples.vb));
    endproperty
    a_src_vb: assert property (p_src_vb) else $error("phase b voltage not sampled");

    property p_src_vc;
        @(posedge clk) disable iff (!rst_n)
        (upd && waveform_source_select == SRC_VC) |=> (wave_valid && wave_sample == $past(samples.vc));
    endproperty
    a_src_vc: assert property (p_src_vc) else $error("phase c voltage not sampled");

    property p_src_ia;
        @(posedge clk) disable iff (!rst_n)
        (upd && waveform_source_select == SRC_IA) |=> (wave_valid && wave_sample == $past(samples.ia));
    endproperty
    a_src_ia: assert property (p_src_ia) else $error("phase a current not sampled");

    property p_src_ib;
        @(posedge clk) disable iff (!rst_n)
        (upd && waveform_source_select == SRC_IB) |=> (wave_valid && wave_sample == $past(samples.ib));
    endproperty
    a_src_ib: assert property (p_src_ib) else $error("phase b current not sampled");

    property p_src_rsv;
        @(posedge clk) disable iff (!rst_n)
        (upd && waveform_source_select > SRC_IC) |=> (!wave_valid && $stable(wave_sample));
    endproperty
    a_src_rsv: assert property (p_src_rsv) else $error("reserved source produced a sample");

    property p_no_swap;
        @(posedge clk) disable iff (!rst_n)
        !line_reactive_swap |=> (line_active_acc_in == $past(line_in.active)
                                 && line_apparent_acc_in == $past(line_in.apparent));
    endproperty
    a_no_swap: assert property (p_no_swap) else $error("plain routing wrong");

    property p_neg_c_off;
        @(posedge clk) disable iff (!rst_n)
        !active_term_select[0] |=> !pulse_numerator_neg[2];
    endproperty
    a_neg_c_off: assert property (p_neg_c_off) else $error("phase c sign shown while disabled");

    property p_neg_b;
        @(posedge clk) disable iff (!rst_n)
        active_term_select[1] |=> (pulse_numerator_neg[1] == $past(terms.second[PW-1]));
    endproperty
    a_neg_b: assert property (p_neg_b) else $error("phase b sign wrong");

    property p_neg_c;
        @(posedge clk) disable iff (!rst_n)
        active_term_select[0] |=> (pulse_numerator_neg[2] == $past(terms.third_p[PW-1]));
    endproperty
    a_neg_c: assert property (p_neg_c) else $error("phase c sign wrong");

    property p_write_wave;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == WAVE_MODE_ADDR) |=> (st.wave_mode == ($past(reg_wdata) & WAVE_MODE_MASK));
    endproperty
    a_write_wave: assert property (p_write_wave) else $error("waveform mode write lost");

    property p_read_act;
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == ACT_MODE_ADDR) |=> (reg_rdata == $past(st.act_mode));
    endproperty
    a_read_act: assert property (p_read_act) else $error("term enable read wrong");

endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the waveform and active term configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import wacfg_pkg::*;
;
    typedef struct {
        string       name;
        logic [31:0] val;
    } wacfg_note_s;

    logic           clk;
    logic           resetn;
    logic [7:0]     reg_addr;
    logic           reg_wr;
    logic           reg_rd;
    logic [7:0]     reg_wdata;
    logic [7:0]     reg_rdata;
    wacfg_samples_s samples;
    wacfg_terms_s   terms;
    wacfg_line_s    line_in;
    logic [SW-1:0]  wave_sample;
    logic           wave_valid;
    logic [PW-1:0]  act_pw;
    logic [PW-1:0]  line_pw;
    logic [PW-1:0]  acc_act;
    logic [PW-1:0]  acc_app;
    logic [2:0]     neg;
    logic [7:0]     act;
    wacfg_note_s    notes[$];
    wacfg_note_s    wnotes[$];
    wacfg_note_s    nt;
    logic [31:0]    lfsr = 32'h2fc00243;
    logic           no_wave = 1'b0;
    int             n;
    int             failures = 0;
    int             num_checks = 0;

    wacfg_top dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .samples(samples), .terms(terms), .line_in(line_in),
        .wave_sample(wave_sample), .wave_valid(wave_valid), .active_power(act_pw), .line_active_power(line_pw),
        .line_active_acc_in(acc_act), .line_apparent_acc_in(acc_app), .pulse_numerator_neg(neg));

    always #2 clk = ~clk;

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
        return lfsr;
    endfunction

    function automatic logic [31:0] pw(logic [2:0] en, logic [1:0] f, wacfg_terms_s t);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        a = (f == FORM_SUM3) ? t.first_p : t.first_d;
        b = (f == FORM_SUM3) ? t.second : 32'h0;
        c = (f == FORM_TWO_AC) ? t.third_d : t.third_p;
        if (f == FORM_RSV) return 32'h0;
        return (en[2] ? a : 32'h0) + (en[1] ? b : 32'h0) + (en[0] ? c : 32'h0);
    endfunction

    function automatic logic [SW-1:0] src_val(logic [2:0] s);
        case (s)
            SRC_VA: return samples.va;
            SRC_VB: return samples.vb;
            SRC_VC: return samples.vc;
            SRC_IA: return samples.ia;
            SRC_IB: return samples.ib;
            default: return samples.ic;
        endcase
    endfunction

    function automatic logic [31:0] seen_of(string s);
        case (s)
            "reg_rdata": return {24'h0, reg_rdata};
            "active_power": return act_pw;
            "line_active_power": return line_pw;
            "line_active_acc_in": return acc_act;
            "line_apparent_acc_in": return acc_app;
            "neg": return {29'h0, neg};
            default: return {8'h0, wave_sample};
        endcase
    endfunction

    task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic note(string s, logic [31:0] v, bit w);
        wacfg_note_s x;
        x.name = s;
        x.val = v;
        if (w) wnotes.push_back(x);
        else notes.push_back(x);
    endtask

    task automatic step(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        note("reg_rdata", {24'h0, e}, 0);
        step(1);
    endtask

    task automatic wait_valid(output int k);
        k = 0;
        while (wave_valid !== 1'b1 && k < 4000) begin
            step(1);
            k++;
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        while (notes.size() > 0) begin
            nt = notes.pop_front();
            check(nt.name, seen_of(nt.name), nt.val);
        end
        if (wave_valid === 1'b1 && no_wave) check("wave_valid", 32'h1, 32'h0);
        else if (wave_valid === 1'b1 && wnotes.size() > 0) begin
            nt = wnotes.pop_front();
            check(nt.name, {8'h0, wave_sample}, nt.val);
        end
    end

    initial begin
        #160000;
        failures++;
        tally_and_finish();
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h0;
        samples = '0;
        terms = '0;
        line_in = '0;
        step(5);
        resetn = 1'b1;
        step(5);
        rd(WAVE_MODE_ADDR, WAVE_MODE_RST);
        rd(ACT_MODE_ADDR, ACT_MODE_RST);
        rd(8'h0e, 8'h00);
        wr(WAVE_MODE_ADDR, 8'hff);
        rd(WAVE_MODE_ADDR, WAVE_MODE_MASK);
        wr(8'h0e, 8'h55);
        rd(ACT_MODE_ADDR, ACT_MODE_RST);
        reg_addr = ACT_MODE_ADDR;
        reg_wdata = 8'h00;
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        step(1);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        note("reg_rdata", {24'h0, ACT_MODE_RST}, 0);
        step(1);
        rd(ACT_MODE_ADDR, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 32; i++) begin
            terms = {rnd(), rnd(), rnd(), rnd(), rnd()};
            act = {i[4:0], 3'(rnd())};
            wr(ACT_MODE_ADDR, act);
            note("active_power", pw(act[5:3], act[7:6], terms), 0);
            note("line_active_power", pw(act[2:0], act[7:6], terms), 0);
            note("neg", {29'h0, act[3] & terms.third_p[PW-1], act[4] & terms.second[PW-1],
                act[5] & terms.first_p[PW-1]}, 0);
        end
        $display("test terms done");
        for (int s = 0; s < 2; s++) begin
            line_in = {rnd(), rnd(), rnd()};
            wr(WAVE_MODE_ADDR, 8'(s << SWAP_BIT));
            note("line_active_acc_in", s ? line_in.reactive : line_in.active, 0);
            note("line_apparent_acc_in", s ? line_in.active : line_in.apparent, 0);
        end
        $display("test swap done");
        for (int s = 0; s < 6; s++) begin
            samples = {SW'(rnd()), SW'(rnd()), SW'(rnd()), SW'(rnd()), SW'(rnd()), SW'(rnd())};
            wr(WAVE_MODE_ADDR, 8'(s));
            note("wave_sample", {8'h0, src_val(3'(s))}, 1);
            wait_valid(n);
            step(1);
        end
        for (int s = 6; s < 8; s++) begin
            wr(WAVE_MODE_ADDR, 8'(s));
            no_wave = 1'b1;
            step(800);
            no_wave = 1'b0;
            note("wave_sample", {8'h0, samples.ic}, 0);
        end
        $display("test source done");
        for (int r = 0; r < 4; r++) begin
            wr(WAVE_MODE_ADDR, 8'(r << RATE_LSB));
            step(2);
            wait_valid(n);
            step(1);
            wait_valid(n);
            check("wave_period", n + 1, 3 * (128 << r));
        end
        $display("test rate done");
        step(2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
